/* rtl/pio_unit.sv */
// programmed i/o instruction unit: sense, strobe, word and byte transfers
// ---------------------------------------------------------------------
// Summary of operation
// - skip-on-true test skips on true answer
// - skip-on-false test skips on false answer
// - plain strobe sends function code, zero data
// - accum/index strobes put register on data
// - interrupt sampled before strobe, unless inhibited
// - word transfers move exactly sixteen bits
// - conditional transfer repeats until true answer
// - interrupt on false word test re-executes
// - eight-bit peripheral returns zero upper byte
// - word loads take input into register
// - masked word loads AND input with register
// - word puts send accum or index
// - zero puts send all-zero word
// - conditional reads load or mask on true
// - conditional writes send register on true
// - byte loads replace low byte only
// - masked byte loads AND low byte only
// - conditional byte reads repeat until true
// - interrupt on false byte test re-executes
// - selector is 5-bit device, 3-bit function
// - width set by instruction, not mode flag
// ---------------------------------------------------------------------
`timescale 1ns/10ps
`include "pio_unit_map.svh"

module pio_unit (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // instruction from the sequencer
   input wire logic cmd_valid_i,
   input wire pio_unit_pkg::pio_cmd_t cmd_i,
   input wire logic [15:0] accum_i,
   input wire logic [15:0] index_i,
   input wire logic irq_pending_i,
   input wire logic irq_inhibit_i,
   // i/o bus toward the peripherals
   output pio_unit_pkg::pio_bus_t bus_o,
   input wire logic sense_resp_i,
   input wire logic [15:0] bus_data_i,
   // results toward the sequencer
   output logic busy_o,
   output logic done_o,
   output pio_unit_pkg::pio_result_t result_o,
   output logic irq_take_o,
   output logic accum_we_o,
   output logic index_we_o,
   output logic [15:0] reg_data_o,
   output logic bad_dev_o
);
   import pio_unit_pkg::*;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   pio_state_t state_q;
   pio_cmd_t cmd_q;
   pio_bus_t bus_q;
   logic [15:0] accum_q;
   logic [15:0] index_q;
   logic irq_q;
   logic is_test, is_cond, is_strobe, is_load, is_put;
   logic is_byte, is_mask, is_index;

   always_comb begin
      is_test = 1'b0;
      is_cond = 1'b0;
      is_strobe = 1'b0;
      is_load = 1'b0;
      is_put = 1'b0;
      is_byte = 1'b0;
      is_mask = 1'b0;
      is_index = 1'b0;
      // width comes from the opcode alone, no mode flag input exists
      case (cmd_q.op)
         OP_TEST_SKIP_ON_TRUE: is_test = 1'b1;
         OP_TEST_SKIP_ON_FALSE: is_test = 1'b1;
         OP_FUNCTION_STROBE: is_strobe = 1'b1;
         OP_FUNCTION_STROBE_ACCUM: is_strobe = 1'b1;
         OP_FUNCTION_STROBE_INDEX: begin
            is_strobe = 1'b1;
            is_index = 1'b1;
         end
         OP_WORD_LOAD_ACCUM: is_load = 1'b1;
         OP_WORD_LOAD_ACCUM_MASKED: begin
            is_load = 1'b1;
            is_mask = 1'b1;
         end
         OP_WORD_LOAD_INDEX: begin
            is_load = 1'b1;
            is_index = 1'b1;
         end
         OP_WORD_LOAD_INDEX_MASKED: begin
            is_load = 1'b1;
            is_index = 1'b1;
            is_mask = 1'b1;
         end
         OP_WORD_PUT_ACCUM: is_put = 1'b1;
         OP_WORD_PUT_INDEX: begin
            is_put = 1'b1;
            is_index = 1'b1;
         end
         OP_WORD_PUT_ZERO: is_put = 1'b1;
         OP_COND_WORD_LOAD_ACCUM: begin
            is_cond = 1'b1;
            is_load = 1'b1;
         end
         OP_COND_WORD_LOAD_ACCUM_MASKED: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_mask = 1'b1;
         end
         OP_COND_WORD_LOAD_INDEX: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_index = 1'b1;
         end
         OP_COND_WORD_LOAD_INDEX_MASKED: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_index = 1'b1;
            is_mask = 1'b1;
         end
         OP_COND_WORD_PUT_ACCUM: begin
            is_cond = 1'b1;
            is_put = 1'b1;
         end
         OP_COND_WORD_PUT_INDEX: begin
            is_cond = 1'b1;
            is_put = 1'b1;
            is_index = 1'b1;
         end
         OP_COND_WORD_PUT_ZERO: begin
            is_cond = 1'b1;
            is_put = 1'b1;
         end
         OP_BYTE_LOAD_ACCUM: begin
            is_load = 1'b1;
            is_byte = 1'b1;
         end
         OP_BYTE_LOAD_ACCUM_MASKED: begin
            is_load = 1'b1;
            is_byte = 1'b1;
            is_mask = 1'b1;
         end
         OP_BYTE_LOAD_INDEX: begin
            is_load = 1'b1;
            is_byte = 1'b1;
            is_index = 1'b1;
         end
         OP_BYTE_LOAD_INDEX_MASKED: begin
            is_load = 1'b1;
            is_byte = 1'b1;
            is_index = 1'b1;
            is_mask = 1'b1;
         end
         OP_COND_BYTE_LOAD_ACCUM: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_byte = 1'b1;
         end
         OP_COND_BYTE_LOAD_ACCUM_MASKED: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_byte = 1'b1;
            is_mask = 1'b1;
         end
         OP_COND_BYTE_LOAD_INDEX: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_byte = 1'b1;
            is_index = 1'b1;
         end
         OP_COND_BYTE_LOAD_INDEX_MASKED: begin
            is_cond = 1'b1;
            is_load = 1'b1;
            is_byte = 1'b1;
            is_index = 1'b1;
            is_mask = 1'b1;
         end
         default: is_test = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // data paths
   // ------------------------------------------------------------------
   logic [15:0] src_reg, put_word, load_word;
   logic zero_put;

   assign src_reg = is_index ? index_q : accum_q;
   assign zero_put = (cmd_q.op == OP_WORD_PUT_ZERO) ||
                     (cmd_q.op == OP_COND_WORD_PUT_ZERO) ||
                     (cmd_q.op == OP_FUNCTION_STROBE);
   assign put_word = zero_put ? `PIO_WORD_ZERO : src_reg;

   always_comb begin
      load_word = bus_data_i;
      if (is_byte) begin
         // high byte kept, low byte loaded or masked
         load_word[15:8] = src_reg[15:8];
         if (is_mask) begin
            load_word[7:0] = bus_data_i[7:0] & src_reg[7:0];
         end else begin
            load_word[7:0] = bus_data_i[7:0];
         end
      end else if (is_mask) begin
         load_word = bus_data_i & src_reg;
      end
   end

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   logic bad_dev;
   assign bad_dev = (cmd_i.dev == `PIO_DEV_CPU);

   // phases: test drives sense strobe, xfer moves data, done reports
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         cmd_q <= '0;
         accum_q <= `PIO_WORD_ZERO;
         index_q <= `PIO_WORD_ZERO;
         irq_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmd_valid_i && !bad_dev) begin
                  cmd_q <= cmd_i;
                  accum_q <= accum_i;
                  index_q <= index_i;
                  // latched before any strobe acts on the device
                  irq_q <= irq_pending_i && !irq_inhibit_i;
                  state_q <= ST_TEST;
               end
            end
            ST_TEST: begin
               if ((is_test || is_cond) || !is_strobe) begin
                  state_q <= ST_XFER;
               end else begin
                  state_q <= ST_XFER;
               end
            end
            ST_XFER: state_q <= ST_DONE;
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // bus drive: one cycle per phase
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bus_q <= '0;
      end else begin
         bus_q <= '0;
         if (state_q == ST_IDLE && cmd_valid_i && !bad_dev) begin
            bus_q.dev <= cmd_i.dev;
            bus_q.func <= cmd_i.func;
         end else if (state_q == ST_TEST) begin
            bus_q.dev <= cmd_q.dev;
            bus_q.func <= cmd_q.func;
            if (is_test || is_cond) begin
               bus_q.sense <= 1'b1;
            end else if (is_strobe) begin
               bus_q.strobe <= 1'b1;
               bus_q.data <= put_word;
            end else if (is_put) begin
               bus_q.data_out <= 1'b1;
               bus_q.data <= put_word;
            end else if (is_load) begin
               bus_q.data_in <= 1'b1;
            end
         end else if (state_q == ST_XFER && is_cond && sense_resp_i) begin
            bus_q.dev <= cmd_q.dev;
            bus_q.func <= cmd_q.func;
            bus_q.data_out <= is_put;
            bus_q.data_in <= is_load;
            bus_q.data <= is_put ? put_word : `PIO_WORD_ZERO;
         end
      end
   end

   // ------------------------------------------------------------------
   // results
   // ------------------------------------------------------------------
   logic cond_go;
   // during xfer the sense answer of the test cycle is on sense_resp_i
   assign cond_go = is_cond && sense_resp_i;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         done_o <= 1'b0;
         result_o <= RES_NEXT;
         irq_take_o <= 1'b0;
         accum_we_o <= 1'b0;
         index_we_o <= 1'b0;
         reg_data_o <= `PIO_WORD_ZERO;
         busy_o <= 1'b0;
         bad_dev_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         irq_take_o <= 1'b0;
         accum_we_o <= 1'b0;
         index_we_o <= 1'b0;
         bad_dev_o <= state_q == ST_IDLE && cmd_valid_i && bad_dev;
         busy_o <= (state_q != ST_IDLE && state_q != ST_DONE) ||
                   (state_q == ST_IDLE && cmd_valid_i && !bad_dev);
         if (state_q == ST_XFER) begin
            done_o <= 1'b1;
            result_o <= RES_NEXT;
            if (cmd_q.op == OP_TEST_SKIP_ON_TRUE) begin
               result_o <= sense_resp_i ? RES_SKIP : RES_NEXT;
            end else if (cmd_q.op == OP_TEST_SKIP_ON_FALSE) begin
               result_o <= sense_resp_i ? RES_NEXT : RES_SKIP;
            end else if (is_cond && !sense_resp_i) begin
               // pc stays on this instruction either way
               result_o <= irq_q ? RES_INTERRUPT : RES_REPEAT;
               irq_take_o <= irq_q;
            end else if (is_strobe) begin
               // interrupt seen before the strobe is still honoured
               result_o <= irq_q ? RES_INTERRUPT : RES_NEXT;
               irq_take_o <= irq_q;
            end
            if (is_load && (!is_cond || cond_go)) begin
               accum_we_o <= !is_index;
               index_we_o <= is_index;
               reg_data_o <= load_word;
            end
         end
      end
   end

   assign bus_o = bus_q;
endmodule

/* rtl/pio_unit_map.svh */
// constants for the programmed i/o instruction unit
`ifndef PIO_UNIT_MAP_SVH
`define PIO_UNIT_MAP_SVH
`define PIO_WORD_W 16
`define PIO_BYTE_W 8
`define PIO_DEV_W 5
`define PIO_FUNC_W 3
`define PIO_SEL_W 8
`define PIO_DEV_CPU 5'h00
`define PIO_WORD_ZERO 16'h0000
`define PIO_BYTE_ZERO 8'h00
`endif

/* rtl/pio_unit_pkg.sv */
// types for the programmed i/o instruction unit
package pio_unit_pkg;
   typedef enum logic [4:0] {
      OP_TEST_SKIP_ON_TRUE = 5'h00,
      OP_TEST_SKIP_ON_FALSE = 5'h01,
      OP_FUNCTION_STROBE = 5'h02,
      OP_FUNCTION_STROBE_ACCUM = 5'h03,
      OP_FUNCTION_STROBE_INDEX = 5'h04,
      OP_WORD_LOAD_ACCUM = 5'h05,
      OP_WORD_LOAD_ACCUM_MASKED = 5'h06,
      OP_WORD_LOAD_INDEX = 5'h07,
      OP_WORD_LOAD_INDEX_MASKED = 5'h08,
      OP_WORD_PUT_ACCUM = 5'h09,
      OP_WORD_PUT_INDEX = 5'h0a,
      OP_WORD_PUT_ZERO = 5'h0b,
      OP_COND_WORD_LOAD_ACCUM = 5'h0c,
      OP_COND_WORD_LOAD_ACCUM_MASKED = 5'h0d,
      OP_COND_WORD_LOAD_INDEX = 5'h0e,
      OP_COND_WORD_LOAD_INDEX_MASKED = 5'h0f,
      OP_COND_WORD_PUT_ACCUM = 5'h10,
      OP_COND_WORD_PUT_INDEX = 5'h11,
      OP_COND_WORD_PUT_ZERO = 5'h12,
      OP_BYTE_LOAD_ACCUM = 5'h13,
      OP_BYTE_LOAD_ACCUM_MASKED = 5'h14,
      OP_BYTE_LOAD_INDEX = 5'h15,
      OP_BYTE_LOAD_INDEX_MASKED = 5'h16,
      OP_COND_BYTE_LOAD_ACCUM = 5'h17,
      OP_COND_BYTE_LOAD_ACCUM_MASKED = 5'h18,
      OP_COND_BYTE_LOAD_INDEX = 5'h19,
      OP_COND_BYTE_LOAD_INDEX_MASKED = 5'h1a
   } pio_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TEST = 2'b01,
      ST_XFER = 2'b10,
      ST_DONE = 2'b11
   } pio_state_t;

   // outcome of one instruction, toward the sequencer
   typedef enum logic [1:0] {
      RES_NEXT = 2'b00,
      RES_SKIP = 2'b01,
      RES_REPEAT = 2'b10,
      RES_INTERRUPT = 2'b11
   } pio_result_t;

   typedef struct packed {
      pio_op_t op;
      logic [4:0] dev;
      logic [2:0] func;
   } pio_cmd_t;

   typedef struct packed {
      logic [4:0] dev;
      logic [2:0] func;
      logic sense;
      logic strobe;
      logic data_in;
      logic data_out;
      logic [15:0] data;
   } pio_bus_t;
endpackage

/* tb/pio_peer.sv */
// peripheral model on the i/o bus
`timescale 1ns/10ps
module pio_peer (
   // clock, reset and bus
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire pio_unit_pkg::pio_bus_t bus_i,
   // behaviour set by the bench
   input wire logic ready_i,
   input wire logic narrow_i,
   input wire logic [15:0] word_i,
   // answers and what was received
   output logic sense_resp_o,
   output logic [15:0] data_o,
   output logic [15:0] got_o,
   output logic [7:0] got_cnt_o
);
   import pio_unit_pkg::*;
   logic sense_last_q;
   logic [15:0] data_last_q;
   // answer within the pulse cycle; released lines show the inverse
   assign sense_resp_o = bus_i.sense ? ready_i : !sense_last_q;
   assign data_o = (bus_i.sense || bus_i.data_in) ?
      (narrow_i ? {8'h00, word_i[7:0]} : word_i) : ~data_last_q;
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sense_last_q <= 1'b0;
         data_last_q <= 16'h0000;
         got_o <= 16'h0000;
         got_cnt_o <= 8'h00;
      end else begin
         sense_last_q <= sense_resp_o;
         data_last_q <= data_o;
         if (bus_i.data_out || bus_i.strobe) begin
            got_o <= narrow_i ? {8'h00, bus_i.data[7:0]} : bus_i.data;
            got_cnt_o <= got_cnt_o + 8'h01;
         end
      end
   end
endmodule

/* tb/pio_unit_properties.sv */
// port assertions for the programmed i/o unit
`timescale 1ns/10ps
module pio_unit_properties (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // sequencer side
   input wire logic cmd_valid_i,
   input wire pio_unit_pkg::pio_cmd_t cmd_i,
   input wire logic [15:0] accum_i,
   input wire logic [15:0] index_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire pio_unit_pkg::pio_result_t result_o,
   input wire logic accum_we_o,
   input wire logic index_we_o,
   input wire logic [15:0] reg_data_o,
   input wire logic bad_dev_o,
   // i/o bus
   input wire pio_unit_pkg::pio_bus_t bus_o,
   input wire logic sense_resp_i
);
   import pio_unit_pkg::*;
   pio_cmd_t c_q;
   logic [15:0] a_q, x_q;
   logic resp_q, resp, take, cnd, idle;
   assign idle = cmd_valid_i && !busy_o && !done_o;
   assign take = idle && cmd_i.dev != 5'h00;
   // answer is the level seen while the sense pulse was out
   assign resp = resp_q;
   assign cnd = c_q.op inside {[OP_COND_WORD_LOAD_ACCUM:OP_COND_WORD_PUT_ZERO],
      [OP_COND_BYTE_LOAD_ACCUM:OP_COND_BYTE_LOAD_INDEX_MASKED]};
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         c_q <= '0;
         a_q <= 16'h0000;
         x_q <= 16'h0000;
         resp_q <= 1'b0;
      end else begin
         if (bus_o.sense)
            resp_q <= sense_resp_i;
         if (take) begin
            c_q <= cmd_i;
            a_q <= accum_i;
            x_q <= index_i;
         end
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   chk_take_done: assert property (take |-> ##[3:4] done_o)
      else $error("no done after command");
   chk_refuse_dev: assert property (
      idle && cmd_i.dev == 5'h00 |-> ##[1:2] (bad_dev_o && !busy_o))
      else $error("device zero not refused");
   chk_strobe_one: assert property (bus_o.strobe |->
      bus_o.dev == c_q.dev && bus_o.func == c_q.func ##1 !bus_o.strobe)
      else $error("strobe not one cycle");
   chk_strobe_zero: assert property (
      bus_o.strobe && c_q.op == OP_FUNCTION_STROBE |-> bus_o.data == 16'h0000)
      else $error("plain strobe data");
   chk_strobe_reg: assert property (
      bus_o.strobe && c_q.op != OP_FUNCTION_STROBE |-> bus_o.data ==
      (c_q.op == OP_FUNCTION_STROBE_ACCUM ? a_q : x_q))
      else $error("register strobe data");
   chk_put_zero: assert property (bus_o.data_out && c_q.op inside
      {OP_WORD_PUT_ZERO, OP_COND_WORD_PUT_ZERO} |-> bus_o.data == 16'h0000)
      else $error("zero put data");
   chk_skip_true: assert property (
      done_o && c_q.op == OP_TEST_SKIP_ON_TRUE |->
      result_o == (resp ? RES_SKIP : RES_NEXT))
      else $error("skip on true");
   chk_skip_false: assert property (
      done_o && c_q.op == OP_TEST_SKIP_ON_FALSE |->
      result_o == (resp ? RES_NEXT : RES_SKIP))
      else $error("skip on false");
   chk_false_hold: assert property (done_o && cnd && !resp |->
      !accum_we_o && !index_we_o && result_o inside {RES_REPEAT, RES_INTERRUPT})
      else $error("false answer transferred");
   chk_byte_high: assert property (
      done_o && accum_we_o && c_q.op >= OP_BYTE_LOAD_ACCUM |->
      reg_data_o[15:8] == a_q[15:8])
      else $error("byte load high byte");
endmodule
bind pio_unit pio_unit_properties chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .accum_i(accum_i),
   .index_i(index_i), .busy_o(busy_o), .done_o(done_o),
   .result_o(result_o), .accum_we_o(accum_we_o), .index_we_o(index_we_o),
   .reg_data_o(reg_data_o), .bad_dev_o(bad_dev_o), .bus_o(bus_o),
   .sense_resp_i(sense_resp_i));

/* tb/programmed_io_instruction_unit_tb.sv */
// self-checking bench for the programmed i/o unit
`timescale 1ns/10ps
module programmed_io_instruction_unit_tb;
   import pio_unit_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   pio_cmd_t cmd_i = '0;
   logic [15:0] accum_i = 16'h0000;
   logic [15:0] index_i = 16'h0000;
   logic irq_pending_i = 1'b0;
   logic irq_inhibit_i = 1'b0;
   logic ready = 1'b0;
   logic narrow = 1'b0;
   logic [15:0] word = 16'h0000;
   pio_bus_t bus_o;
   pio_result_t result_o;
   logic sense_resp_i, busy_o, done_o, irq_take_o;
   logic accum_we_o, index_we_o, bad_dev_o;
   logic [15:0] bus_data_i, reg_data_o, got;
   logic [7:0] got_cnt;
   logic [31:0] seed = 32'h01373f42;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   pio_unit uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .accum_i(accum_i),
      .index_i(index_i), .irq_pending_i(irq_pending_i),
      .irq_inhibit_i(irq_inhibit_i), .bus_o(bus_o),
      .sense_resp_i(sense_resp_i), .bus_data_i(bus_data_i),
      .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
      .irq_take_o(irq_take_o), .accum_we_o(accum_we_o),
      .index_we_o(index_we_o), .reg_data_o(reg_data_o),
      .bad_dev_o(bad_dev_o));
   pio_peer peer (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_o),
      .ready_i(ready), .narrow_i(narrow), .word_i(word),
      .sense_resp_o(sense_resp_i), .data_o(bus_data_i), .got_o(got),
      .got_cnt_o(got_cnt));
   // ------
   // helpers
   // ------
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [15:0] exp_reg(logic [4:0] o, logic [15:0] b,
      logic [15:0] d);
      logic m;
      m = o inside {5'h06, 5'h08, 5'h0d, 5'h0f, 5'h14, 5'h16, 5'h18, 5'h1a};
      if (o < 5'h13)
         return m ? (b & d) : d;
      return {b[15:8], m ? (b[7:0] & d[7:0]) : d[7:0]};
   endfunction
   function logic [15:0] exp_out(logic [4:0] o, logic [15:0] a,
      logic [15:0] x);
      if (o inside {5'h03, 5'h09, 5'h10})
         return a;
      if (o inside {5'h04, 5'h0a, 5'h11})
         return x;
      return 16'h0000;
   endfunction
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("[FAIL] %0t run too long", $time);
         close_out();
      end
   end
   // one instruction, next one a cycle after the earliest legal cycle
   task automatic issue(input logic [4:0] o, input logic rdy);
      logic [15:0] a, x, d, w;
      logic [31:0] r;
      logic [7:0] c0;
      logic cnd, ld, ta, fire, ir, ih;
      int n;
      a = rnd();
      x = rnd();
      d = rnd();
      r = rnd();
      cnd = o inside {[5'h0c:5'h12], [5'h17:5'h1a]};
      ld = o inside {[5'h05:5'h08], [5'h0c:5'h0f], [5'h13:5'h1a]};
      ta = o inside {5'h05, 5'h06, 5'h0c, 5'h0d, 5'h13, 5'h14, 5'h17, 5'h18};
      fire = !cnd || rdy;
      ir = r[0] && (o inside {[5'h02:5'h04]} || !fire);
      ih = r[1] && !cnd;
      w = r[2] ? {8'h00, d[7:0]} : d;
      @(negedge mclk_i);
      cmd_i = '{pio_op_t'(o), 5'(rnd() % 31 + 1), 3'(r[6:4])};
      cmd_valid_i = 1'b1;
      accum_i = a;
      index_i = x;
      irq_pending_i = ir;
      irq_inhibit_i = ih;
      ready = rdy;
      narrow = r[2];
      word = d;
      c0 = got_cnt;
      @(negedge mclk_i);
      cmd_valid_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 8) begin
         @(negedge mclk_i);
         n++;
      end
      chk(done_o === 1'b1, "no done");
      if (ld && fire) begin
         chk(accum_we_o === ta && index_we_o === !ta, "write enable");
         chk(reg_data_o === exp_reg(o, ta ? a : x, w), "load value");
      end else
         chk(!accum_we_o && !index_we_o, "stray write");
      if (o < 5'h02)
         chk(result_o === ((rdy ^ o[0]) ? RES_SKIP : RES_NEXT), "skip");
      else if (!fire)
         chk(result_o inside {RES_REPEAT, RES_INTERRUPT} &&
            irq_take_o === ir, "false answer");
      else if (o > 5'h04)
         chk(result_o === RES_NEXT, "next result");
      else
         chk(irq_take_o === (ir && !ih), "strobe interrupt");
      // conditional puts reach the peripheral in the same cycle as done
      @(negedge mclk_i);
      if (o inside {[5'h02:5'h04], [5'h09:5'h0b], [5'h10:5'h12]}) begin
         chk(got_cnt === c0 + (fire ? 8'h01 : 8'h00), "put count");
         if (fire)
            chk(got === (exp_out(o, a, x) &
               (r[2] ? 16'h00ff : 16'hffff)), "put word");
      end
   endtask
   initial begin
      repeat (20) @(negedge mclk_i);
      rst_b_i = 1'b1;
      @(negedge mclk_i);
      cmd_i = '{OP_WORD_PUT_ACCUM, 5'h00, 3'h1};
      cmd_valid_i = 1'b1;
      @(negedge mclk_i);
      chk(bad_dev_o === 1'b1, "device zero flag");
      cmd_valid_i = 1'b0;
      @(negedge mclk_i);
      chk(busy_o === 1'b0 && done_o === 1'b0, "device zero taken");
      $display("test device zero done");
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 27; i++) begin
            if (i inside {[12:18], [23:26]}) begin
               issue(5'(i), 1'b0);
               issue(5'(i), 1'b1);
            end else
               issue(5'(i), 1'(rnd()));
         end
         $display("test sweep round %0d done", k);
      end
      close_out();
   end
endmodule
